//--- core/mtm_timer.sv
// Three-channel multi-mode 16-bit timer with an APB register slave.
// Assumes pins and the secondary clock are asynchronous levels; one system clock.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module mtm_timer (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Secondary clock input
  input  wire logic        sub_clk_i,
  // Channel pins
  input  wire logic [2:0]  chan_io_pin_i,
  output logic      [2:0]  chan_io_pin_o,
  output logic      [2:0]  chan_io_pin_oe_n_o,
  // Channel interrupt requests
  output logic      [2:0]  irq_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rel;
    logic [15:0] meas;
    logic [11:0] mode;
    logic [1:0]  edges;
    logic        act;
    logic        pout;
    logic        ovf;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        lvl;
  } mtm_chan_t;

  typedef struct packed {
    mtm_chan_t [2:0] ch;
    logic [2:0]      start;
    logic [2:0]      updown;
    logic [4:0]      div;
    logic [4:0]      sdiv;
    logic            ss1;
    logic            ss2;
    logic            ss3;
    logic            slvl;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [2:0]      irq;
    logic [2:0]      oe_n;
  } mtm_state_t;

  mtm_state_t        s_q;
  mtm_state_t        s_d;
  mtm_chan_t         c;
  mtm_pkg::mtm_mode_t md;
  logic              acc;
  logic              wr;
  logic              map_hit;
  logic              fc_tick;
  logic              tick;
  logic              run;
  logic              rise;
  logic              fall;
  logic              edge_sel;
  logic              ev_src;
  logic              ev;
  logic              trig;
  logic              gate_ok;
  logic              drive;
  logic [1:0]        fsel;
  logic [7:0]        ch_base;
  logic [31:0]       rdata;

  // Selected count source enable
  function automatic logic src_tick(input logic [1:0] sel, input logic [4:0] div, input logic fc);
    logic t;
    t = 1'b0;
    unique case (mtm_pkg::mtm_src_t'(sel))
      mtm_pkg::SRC_MAIN_UNDIV: t = 1'b1;
      mtm_pkg::SRC_MAIN_DIV8:  t = (div[2:0] == mtm_pkg::DIV8_LAST[2:0]);
      mtm_pkg::SRC_MAIN_DIV32: t = (div == mtm_pkg::DIV32_LAST);
      mtm_pkg::SRC_SUB_DIV32:  t = fc;
    endcase
    return t;
  endfunction

  // Channel register window base
  function automatic logic [7:0] chan_base(input int unsigned k);
    return 8'(mtm_pkg::OFS_CH_BASE + 8'(k) * mtm_pkg::OFS_CH_STEP);
  endfunction

  always_comb
  begin
    s_d      = s_q;
    c        = s_q.ch[0];
    md       = mtm_pkg::MD_TIMER;
    tick     = 1'b0;
    run      = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    edge_sel = 1'b0;
    ev_src   = 1'b0;
    ev       = 1'b0;
    trig     = 1'b0;
    gate_ok  = 1'b0;
    drive    = 1'b0;
    fsel     = 2'b00;
    ch_base  = 8'h00;
    rdata    = 32'h0000_0000;
    map_hit  = 1'b0;
    s_d.irq  = 3'b000;

    // Main clock prescaler
    s_d.div = s_q.div + 5'h01;

    // Secondary clock synchroniser and divide by 32
    s_d.ss1 = sub_clk_i;
    s_d.ss2 = s_q.ss1;
    s_d.ss3 = s_q.ss2;
    if (s_q.ss2 == s_q.ss3)
    begin
      s_d.slvl = s_q.ss3;
    end
    fc_tick = 1'b0;
    if (s_d.slvl && !s_q.slvl)
    begin
      fc_tick  = (s_q.sdiv == mtm_pkg::DIV32_LAST);
      s_d.sdiv = s_q.sdiv + 5'h01;
    end

    // APB handshake: answer in the second access cycle
    acc         = psel_i && penable_i && s_q.pready;
    wr          = acc && pwrite_i;
    s_d.pready  = psel_i && penable_i && !s_q.pready;
    s_d.pslverr = 1'b0;

    if (wr && paddr_i == mtm_pkg::OFS_START)
    begin
      s_d.start = pwdata_i[2:0];
      if (pwdata_i[mtm_pkg::START_PSC_RST_BIT])
      begin
        s_d.sdiv = 5'h00;
      end
    end
    if (wr && paddr_i == mtm_pkg::OFS_UPDOWN)
    begin
      s_d.updown = pwdata_i[2:0];
    end

    for (int i = 0; i < 3; i++)
    begin
      c       = s_q.ch[i];
      ch_base = chan_base(i);
      run     = s_q.start[i];

      // Pin synchroniser; a change counts once stages two and three agree
      c.s1 = chan_io_pin_i[i];
      c.s2 = s_q.ch[i].s1;
      c.s3 = s_q.ch[i].s2;
      if (s_q.ch[i].s2 == s_q.ch[i].s3)
      begin
        c.lvl = s_q.ch[i].s3;
      end
      rise     = c.lvl && !s_q.ch[i].lvl;
      fall     = !c.lvl && s_q.ch[i].lvl;
      edge_sel = s_q.ch[i].mode[mtm_pkg::EDGE_FALL_BIT] ? fall : rise;
      tick     = src_tick(s_q.ch[i].mode[mtm_pkg::SRC_SEL_LSB +: 2], s_q.div, fc_tick);
      fsel     = s_q.ch[i].mode[mtm_pkg::FUNC_SEL_LSB +: 2];
      md       = mtm_pkg::mtm_mode_t'(s_q.ch[i].mode[2:0]);
      ev       = 1'b0;

      // Register writes
      if (wr && paddr_i == ch_base + mtm_pkg::OFS_MODE)
      begin
        c.mode  = pwdata_i[11:0];
        c.act   = 1'b0;
        c.pout  = 1'b0;
        c.edges = 2'h0;
        if (run)
        begin
          c.ovf = 1'b0;
        end
      end
      if (wr && paddr_i == ch_base + mtm_pkg::OFS_TIMER && md != mtm_pkg::MD_PERIOD
          && md != mtm_pkg::MD_WIDTH)
      begin
        c.rel = pwdata_i[15:0];
        if (!run)
        begin
          c.cnt = pwdata_i[15:0];
        end
      end
      if (!run)
      begin
        c.act   = 1'b0;
        c.edges = 2'h0;
      end

      // Counting per mode
      unique case (md)
        mtm_pkg::MD_TIMER:
        begin
          gate_ok = (fsel != mtm_pkg::FN_GATE) || c.lvl;
          if (run && tick && gate_ok)
          begin
            if (c.cnt == 16'h0000)
            begin
              c.cnt = c.rel;
              ev    = 1'b1;
            end
            else
            begin
              c.cnt = c.cnt - 16'h0001;
            end
          end
        end
        mtm_pkg::MD_EVENT:
        begin
          ev_src = s_q.ch[i].mode[mtm_pkg::EV_SRC_BIT] ? s_q.irq[(i + 2) % 3] : edge_sel;
          if (run && ev_src)
          begin
            if (s_q.updown[i])
            begin
              if (c.cnt == mtm_pkg::CNT_MAX)
              begin
                c.cnt = s_q.ch[i].mode[mtm_pkg::FREERUN_BIT] ? 16'h0000 : c.rel;
                ev    = 1'b1;
              end
              else
              begin
                c.cnt = c.cnt + 16'h0001;
              end
            end
            else if (c.cnt == 16'h0000)
            begin
              c.cnt = s_q.ch[i].mode[mtm_pkg::FREERUN_BIT] ? mtm_pkg::CNT_MAX : c.rel;
              ev    = 1'b1;
            end
            else
            begin
              c.cnt = c.cnt - 16'h0001;
            end
          end
        end
        mtm_pkg::MD_ONESHOT:
        begin
          if (c.act && tick)
          begin
            if (c.cnt == 16'h0001)
            begin
              c.act = 1'b0;
              ev    = 1'b1;
            end
            else
            begin
              c.cnt = c.cnt - 16'h0001;
            end
          end
          if (wr && paddr_i == mtm_pkg::OFS_ONESHOT && pwdata_i[i] && run && c.rel != 16'h0000)
          begin
            c.act = 1'b1;
            c.cnt = c.rel;
          end
          c.pout = c.act;
        end
        mtm_pkg::MD_PERIOD, mtm_pkg::MD_WIDTH:
        begin
          if (run)
          begin
            if (tick)
            begin
              if (c.cnt == mtm_pkg::CNT_MAX)
              begin
                c.ovf = 1'b1;
                ev    = 1'b1;
              end
              c.cnt = c.cnt + 16'h0001;
            end
            if ((md == mtm_pkg::MD_PERIOD) ? edge_sel : (rise || fall))
            begin
              c.meas = c.cnt;
              c.cnt  = 16'h0000;
              if (c.edges != 2'h0)
              begin
                ev = 1'b1;
              end
              if (c.edges != mtm_pkg::MEAS_VALID)
              begin
                c.edges = c.edges + 2'h1;
              end
            end
          end
        end
        mtm_pkg::MD_PWM16, mtm_pkg::MD_PWM8:
        begin
          trig = s_q.ch[i].mode[mtm_pkg::TRIG_SEL_BIT] ? s_q.irq[(i + 2) % 3] : 1'b1;
          if (run && trig)
          begin
            c.act = 1'b1;
          end
          if (run && s_q.ch[i].act && tick)
          begin
            if (md == mtm_pkg::MD_PWM16)
            begin
              if (c.cnt == mtm_pkg::PWM16_LAST)
              begin
                c.cnt = 16'h0000;
                ev    = 1'b1;
              end
              else
              begin
                c.cnt = c.cnt + 16'h0001;
              end
            end
            else if (c.cnt[7:0] == 8'h00)
            begin
              c.cnt[7:0] = c.rel[7:0];
              if (c.cnt[15:8] == mtm_pkg::PWM8_LAST)
              begin
                c.cnt[15:8] = 8'h00;
                ev          = 1'b1;
              end
              else
              begin
                c.cnt[15:8] = c.cnt[15:8] + 8'h01;
              end
            end
            else
            begin
              c.cnt[7:0] = c.cnt[7:0] - 8'h01;
            end
          end
          if (md == mtm_pkg::MD_PWM16)
          begin
            c.pout = c.act && (c.cnt < c.rel);
          end
          else
          begin
            c.pout = c.act && (c.cnt[15:8] < c.rel[15:8]);
          end
        end
        default:
        begin
          c.act = 1'b0;
        end
      endcase

      // Pulse output in timer and event modes toggles the pin level and its status bit
      if (ev && fsel == mtm_pkg::FN_PULSE && (md == mtm_pkg::MD_TIMER || md == mtm_pkg::MD_EVENT))
      begin
        c.pout = !c.pout;
      end

      // Pin drives only for output functions; event mode with pulse output drives it even while counting its edges
      drive = ((md == mtm_pkg::MD_TIMER || md == mtm_pkg::MD_EVENT) && fsel == mtm_pkg::FN_PULSE)
              || md == mtm_pkg::MD_ONESHOT || md == mtm_pkg::MD_PWM16 || md == mtm_pkg::MD_PWM8;
      s_d.oe_n[i] = !drive;
      s_d.irq[i]  = ev;
      s_d.ch[i]   = c;

      // Channel reads
      if (paddr_i == ch_base + mtm_pkg::OFS_MODE)
      begin
        map_hit = 1'b1;
        rdata   = {20'h00000, s_q.ch[i].mode};
      end
      if (paddr_i == ch_base + mtm_pkg::OFS_TIMER)
      begin
        map_hit = 1'b1;
        if (md == mtm_pkg::MD_TIMER || md == mtm_pkg::MD_EVENT)
        begin
          rdata = {16'h0000, s_q.ch[i].cnt};
        end
        else if ((md == mtm_pkg::MD_PERIOD || md == mtm_pkg::MD_WIDTH)
                 && s_q.ch[i].edges == mtm_pkg::MEAS_VALID)
        begin
          rdata = {16'h0000, s_q.ch[i].meas};
        end
        else
        begin
          rdata = 32'h0000_0000;
        end
      end
    end

    // Global reads
    unique case (paddr_i)
      mtm_pkg::OFS_START:
      begin
        map_hit = 1'b1;
        rdata   = {29'h0000_0000, s_q.start};
      end
      mtm_pkg::OFS_UPDOWN:
      begin
        map_hit = 1'b1;
        rdata   = {29'h0000_0000, s_q.updown};
      end
      mtm_pkg::OFS_ONESHOT:
      begin
        map_hit = 1'b1;
        rdata   = 32'h0000_0000;
      end
      mtm_pkg::OFS_STATUS:
      begin
        map_hit = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
          rdata[mtm_pkg::STAT_OVF_LSB + k]  = s_q.ch[k].ovf;
          rdata[mtm_pkg::STAT_LVL_LSB + k]  = s_q.ch[k].lvl;
          rdata[mtm_pkg::STAT_POUT_LSB + k] = s_q.ch[k].pout;
        end
      end
      default:
      begin
        rdata = rdata;
      end
    endcase

    if (psel_i && penable_i && !s_q.pready)
    begin
      s_d.prdata  = pwrite_i ? 32'h0000_0000 : rdata;
      s_d.pslverr = !map_hit;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      s_q      <= '0;
      s_q.oe_n <= 3'b111;
      for (int k = 0; k < 3; k++)
      begin
        s_q.ch[k].ovf <= mtm_pkg::OVF_RST;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  always_comb
  begin
    prdata_o  = s_q.prdata;
    pready_o  = s_q.pready;
    pslverr_o = s_q.pslverr;
    irq_o     = s_q.irq;
    for (int k = 0; k < 3; k++)
    begin
      chan_io_pin_o[k] = s_q.ch[k].pout;
    end
    chan_io_pin_oe_n_o = s_q.oe_n;
  end

endmodule

//--- core/mtm_pkg.sv
// Constants and types for the three-channel multi-mode 16-bit timer.
// Assumes a 250 MHz system clock and APB access with 32-bit data.
package mtm_pkg;

  // Channel count and widths
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MODE_W = 12;

  // Register byte offsets
  localparam logic [7:0] OFS_START   = 8'h00;
  localparam logic [7:0] OFS_UPDOWN  = 8'h04;
  localparam logic [7:0] OFS_ONESHOT = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_CH_BASE = 8'h10;
  localparam logic [7:0] OFS_CH_STEP = 8'h10;
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_TIMER   = 8'h04;

  // Start register fields
  localparam int unsigned START_PSC_RST_BIT = 3;

  // Channel mode register fields
  localparam int unsigned MODE_SEL_LSB  = 0;
  localparam int unsigned SRC_SEL_LSB   = 3;
  localparam int unsigned FUNC_SEL_LSB  = 5;
  localparam int unsigned EV_SRC_BIT    = 8;
  localparam int unsigned FREERUN_BIT   = 9;
  localparam int unsigned EDGE_FALL_BIT = 10;
  localparam int unsigned TRIG_SEL_BIT  = 11;

  // Status register fields
  localparam int unsigned STAT_OVF_LSB  = 0;
  localparam int unsigned STAT_LVL_LSB  = 3;
  localparam int unsigned STAT_POUT_LSB = 6;

  // Count values
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [15:0] PWM16_LAST    = 16'hfffe;
  localparam logic [7:0]  PWM8_LAST     = 8'hfe;
  localparam logic [4:0]  DIV8_LAST     = 5'h07;
  localparam logic [4:0]  DIV32_LAST    = 5'h1f;
  localparam logic [1:0]  MEAS_VALID    = 2'h2;
  localparam logic        OVF_RST       = 1'b1;

  typedef enum logic [2:0] {
    MD_TIMER  = 3'b000,
    MD_EVENT  = 3'b001,
    MD_ONESHOT= 3'b010,
    MD_PERIOD = 3'b011,
    MD_WIDTH  = 3'b100,
    MD_PWM16  = 3'b101,
    MD_PWM8   = 3'b110
  } mtm_mode_t;

  typedef enum logic [1:0] {
    SRC_MAIN_UNDIV = 2'b00,
    SRC_MAIN_DIV8  = 2'b01,
    SRC_MAIN_DIV32 = 2'b10,
    SRC_SUB_DIV32  = 2'b11
  } mtm_src_t;

  typedef enum logic [1:0] {
    FN_NONE  = 2'b00,
    FN_PULSE = 2'b01,
    FN_GATE  = 2'b10
  } mtm_func_t;

endpackage

//--- tb/mtm_timer_monitor.sv
// Concurrent checks on the timer's APB ports, all three interrupts and channel 0 ports.
// Assumes it is bound into mtm_timer and sees only its ports.
module mtm_timer_monitor (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  // APB slave
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Secondary clock, pins, interrupts
  input wire logic        sub_clk_i,
  input wire logic [2:0]  chan_io_pin_i,
  input wire logic [2:0]  chan_io_pin_o,
  input wire logic [2:0]  chan_io_pin_oe_n_o,
  input wire logic [2:0]  irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  logic        wr;
  logic        wr_q;
  logic        seen_q;
  logic [2:0]  run_q;
  logic [2:0]  runp_q;
  logic [11:0] md_q;
  logic [15:0] rel_q;
  logic [15:0] gap_q;
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  // Shadow of channel 0 set-up, gaps between its interrupts
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      {wr_q, seen_q, run_q, runp_q, md_q, rel_q, gap_q} <= '0;
    end
    else
    begin
      wr_q   <= wr;
      runp_q <= run_q;
      gap_q  <= irq_o[0] ? 16'h0001 : gap_q + 16'h0001;
      seen_q <= (irq_o[0] | seen_q) & ~wr & ~wr_q;
      if (wr && paddr_i == 8'h00)
        run_q <= pwdata_i[2:0];
      if (wr && paddr_i == 8'h10)
        md_q <= pwdata_i[11:0];
      if (wr && paddr_i == 8'h14)
        rel_q <= pwdata_i[15:0];
    end
  end
  property p_ready_wait;
    psel_i && $rose(penable_i) |=> pready_o;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err_ready;
    pslverr_o |-> pready_o && psel_i && penable_i;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside access");
  property p_wr_zero;
    pready_o && pwrite_i |-> prdata_o == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
  property p_irq_run;
    (irq_o & ~(run_q | runp_q)) == 3'h0;
  endproperty
  a_irq_run: assert property (p_irq_run) else $error("irq while stopped");
  property p_gap;
    irq_o[0] && seen_q && run_q[0] && runp_q[0] && md_q[4:0] == 5'h00 && md_q[6:5] != 2'h2
      |-> gap_q == rel_q + 16'h0001;
  endproperty
  a_gap: assert property (p_gap) else $error("wrong division ratio");
  property p_gate_in;
    md_q[2:0] == 3'h0 && md_q[6:5] == 2'h2 && $stable(md_q) |-> chan_io_pin_oe_n_o[0];
  endproperty
  a_gate_in: assert property (p_gate_in) else $error("gate pin driven");
  property p_pulse_tgl;
    irq_o[0] && md_q[2:0] == 3'h0 && md_q[6:5] == 2'h1 && $stable(md_q)
      |-> ##[0:1] $changed(chan_io_pin_o[0]);
  endproperty
  a_pulse_tgl: assert property (p_pulse_tgl) else $error("no toggle");
  property p_drive;
    md_q[2:0] == 3'h0 && md_q[6:5] == 2'h1 && run_q[0] && runp_q[0] |-> !chan_io_pin_oe_n_o[0];
  endproperty
  a_drive: assert property (p_drive) else $error("pulse pin not driven");
  c_irq: cover property (irq_o[0]);
  c_err: cover property (pslverr_o);
  c_gate: cover property (md_q[6:5] == 2'h2 && irq_o[0]);
endmodule

bind mtm_timer mtm_timer_monitor u_mon (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sub_clk_i(sub_clk_i), .chan_io_pin_i(chan_io_pin_i),
  .chan_io_pin_o(chan_io_pin_o), .chan_io_pin_oe_n_o(chan_io_pin_oe_n_o), .irq_o(irq_o)
);

//--- tb/mtm_pin_model.sv
// Far side of the channel pins: held levels or a square wave.
// Assumes the device's active-low enable decides who drives a pin.
module mtm_pin_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Bench control
  input  wire logic [2:0] lvl_i,
  input  wire logic [2:0] gen_i,
  input  wire logic [7:0] half_i,
  // Device side
  input  wire logic [2:0] dev_out_i,
  input  wire logic [2:0] dev_oe_n_i,
  output logic      [2:0] pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q = 8'h00;
  logic       sq_q  = 1'b0;
  // Square wave toggles every half_i cycles
  always @(posedge clk_sys_i)
  begin
    cnt_q <= (cnt_q + 8'h01 >= half_i) ? 8'h00 : cnt_q + 8'h01;
    if (cnt_q + 8'h01 >= half_i)
      sq_q <= ~sq_q;
  end
  // Model lets go where the device drives
  always_comb
    for (int c = 0; c < 3; c++)
      pin_o[c] = !dev_oe_n_i[c] ? dev_out_i[c] : (gen_i[c] ? sq_q : lvl_i[c]);
endmodule

//--- tb/tb_multi_mode_16bit_timer.sv
// Self-checking bench: register rows, then timer modes and reset.
// Assumes the design, pin model and bound monitor compile before it.
module tb_multi_mode_16bit_timer;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        x;
  } mtm_row_t;
  logic        clk_sys_i;
  logic        nrst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic        sub_clk_i;
  logic        pready_o;
  logic        pslverr_o;
  logic        err;
  logic [7:0]  paddr_i;
  logic [7:0]  half;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic [2:0]  pin_i;
  logic [2:0]  pin_o;
  logic [2:0]  oe_n;
  logic [2:0]  irq_o;
  logic [2:0]  lvl;
  logic [2:0]  gen;
  int          fail_count;
  int          samples_checked;
  int          g;
  int          i;
  int          divs [4] = '{1, 8, 32, 320};
  mtm_row_t    rows [10];

  mtm_timer uut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sub_clk_i(sub_clk_i), .chan_io_pin_i(pin_i),
    .chan_io_pin_o(pin_o), .chan_io_pin_oe_n_o(oe_n), .irq_o(irq_o)
  );
  mtm_pin_model u_pins (
    .clk_sys_i(clk_sys_i), .lvl_i(lvl), .gen_i(gen), .half_i(half),
    .dev_out_i(pin_o), .dev_oe_n_i(oe_n), .pin_o(pin_i)
  );

  task automatic tally_and_finish();
    $display("Counts: %0d checked, %0d failed", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    chk(32'h0, 32'h1);
    tally_and_finish();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 50);
    if (k >= 50)
      give_up();
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_irq(input int c, output int k);
    for (k = 1; irq_o[c] !== 1'b1; k++)
    begin
      @(posedge clk_sys_i);
      if (k > 4000)
        give_up();
    end
  endtask

  task automatic gap(input int c, output int n);
    wait_irq(c, n);
    @(posedge clk_sys_i);
    wait_irq(c, n);
  endtask

  task automatic count(input int n, input bit pin, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      k += pin ? int'(pin_o[0]) : int'(irq_o[0]);
    end
  endtask

  task automatic setup0(input logic [31:0] md, input logic [31:0] t, input logic [31:0] st);
    wr(8'h00, 32'h0);
    wr(8'h10, md);
    wr(8'h14, t);
    wr(8'h00, st);
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    sub_clk_i = 1'b0;
    forever
    begin
      repeat (5) @(posedge clk_sys_i);
      sub_clk_i <= ~sub_clk_i;
    end
  end

  initial
  begin
    {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {lvl, gen, half, fail_count, samples_checked} = '0;
    rows = '{'{0, 8'h0c, 0, 32'h7, 0}, '{1, 8'h04, 5, 0, 0}, '{0, 8'h04, 0, 5, 0},
             '{1, 8'h00, 8, 0, 0}, '{0, 8'h00, 0, 0, 0}, '{1, 8'h24, 32'h1234, 0, 0},
             '{0, 8'h24, 0, 32'h1234, 0}, '{0, 8'h08, 0, 0, 0}, '{1, 8'h50, 1, 0, 1},
             '{0, 8'hfc, 0, 0, 1}};
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(rd, rows[i].e);
      chk({31'h0, err}, {31'h0, rows[i].x});
    end
    $display("Register rows done");
    for (i = 0; i < 4; i++)
    begin
      setup0(32'h20 | 32'(i << 3), 32'h1, 32'h1);
      gap(0, g);
      chk(g, 2 * divs[i]);
      chk({31'h0, oe_n[0]}, 32'h0);
    end
    $display("Count sources done");
    setup0(32'h0, 32'h40, 32'h1);
    wr(8'h14, 32'h3);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, rd[15:0] > 16'h3}, 32'h1);
    repeat (80) @(posedge clk_sys_i);
    gap(0, g);
    chk(g, 4);
    $display("Running write done");
    setup0(32'h40, 32'h3, 32'h1);
    count(40, 1'b0, g);
    chk(g, 0);
    lvl <= 3'h1;
    gap(0, g);
    chk(g, 4);
    lvl <= 3'h0;
    $display("Gate done");
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h2);
    wr(8'h00, 32'h2);
    half <= 8'h04;
    gen  <= 3'h2;
    gap(1, g);
    chk(g, 24);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h2);
    wr(8'h24, 32'hfffd);
    wr(8'h00, 32'h2);
    gap(1, g);
    chk(g, 24);
    gen <= 3'h0;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h20, 32'h201);
    wr(8'h24, 32'h1);
    wr(8'h00, 32'h2);
    repeat (4)
    begin
      repeat (6) @(posedge clk_sys_i);
      lvl <= lvl ^ 3'h2;
    end
    repeat (8) @(posedge clk_sys_i);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'hffff);
    $display("Event counter done");
    wr(8'h30, 32'h3);
    wr(8'h34, 32'h55);
    wr(8'h00, 32'h4);
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h0);
    gen <= 3'h4;
    for (i = 10; i < 20; i += 5)
    begin
      half <= 8'(i);
      repeat (100) @(posedge clk_sys_i);
      apb(1'b0, 8'h34, 32'h0);
      chk({31'h0, rd + 1 >= 2 * i && rd <= 2 * i + 1}, 32'h1);
    end
    wr(8'h30, 32'h4);
    repeat (40) @(posedge clk_sys_i);
    gap(2, g);
    chk(g, 15);
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, 32'hf);
    $display("Period measure done");
    setup0(32'h2, 32'h6, 32'h1);
    wr(8'h08, 32'h1);
    count(40, 1'b1, g);
    chk(g, 6);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    setup0(32'h6, 32'h300, 32'h1);
    repeat (300) @(posedge clk_sys_i);
    count(510, 1'b1, g);
    chk(g, 6);
    wr(8'h20, 32'h101);
    wr(8'h24, 32'h1);
    wr(8'h00, 32'h3);
    gap(1, g);
    chk(g, 510);
    $display("One-shot and PWM done");
    lvl    <= 3'h0;
    gen    <= 3'h0;
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    chk({29'h0, oe_n}, 32'h7);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    $display("Reset done");
    tally_and_finish();
  end
endmodule
